// ==== spl_defs.svh ====
// What this block does
// R1 - controller loads known pattern before receive timing calibration starts
// R2 - each serial load packet delivers exactly one byte into the holding register
// R3 - every load packet shifts holding register by eight bits, new byte in
// R4 - one full load sequence fills one column, same packet for all widths
// R5 - sub-columns per column: one at x16, two at x8, four at x4
// R6 - controller issues one column write per sub-column, selected by sub-column field
// R7 - load words 0..15 land in core words 15,7,11,3,13,5,9,1,0,8,4,12,2,10,6,14
// R8 - write enables: all at x16, halves at x8, quarters at x4 by select
// R9 - core word n maps to pin n, n mod 8, n mod 4; bit 0 first
// R10 - word sent as two bytes, bits 15,11,7,3,14,10,6,2 then 13,9,5,1,12,8,4,0
// R11 - width code 010 is x4, 011 is x8, 100 is x16; others unsupported
// R12 - serial inputs sampled on falling edge of the serial clock
// R13 - device holds a six-bit serial device identifier for directed transactions
// R14 - holding register is 256 bits and keeps contents until reloaded
`ifndef SPL_DEFS_SVH
`define SPL_DEFS_SVH
`define SPL_WIDTH_X4 3'h2
`define SPL_WIDTH_X8 3'h3
`define SPL_WIDTH_X16 3'h4
`define SPL_BYTE_BITS 8
`define SPL_WORDS 16
`define SPL_WORD_BITS 16
`define SPL_SID_BITS 6
`endif

// ==== spl_pkg.sv ====
package spl_pkg;
    typedef logic [15:0] spl_word_t;
    typedef logic [15:0] spl_wen_t;
    typedef enum logic [1:0] {SPL_W_X4, SPL_W_X8, SPL_W_X16, SPL_W_BAD} spl_width_t;
endpackage : spl_pkg

// ==== spl_load.sv ====
`timescale 1ns/1ps
`include "spl_defs.svh"
module spl_load
    import spl_pkg::*;
#(
    parameter int WORDS = `SPL_WORDS
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic serial_clk,
    input wire logic serial_rst,
    input wire logic load_valid,
    input wire logic [7:0] load_byte,
    input wire logic [5:0] load_target_id,
    input wire logic [5:0] serial_device_identifier,
    input wire logic [2:0] width_cfg,
    input wire logic col_write,
    input wire logic [3:0] subcolumn_select,
    output logic core_write_q,
    output logic [15:0] core_wen_q,
    output logic [255:0] core_data_q,
    output logic width_bad_q,
    output logic [15:0] dq_pin_map_q
);
    initial begin
        if (WORDS != 16) $error("spl_load serves sixteen words only");
    end

    // serial side, falling edge sampling, shift register
    logic [255:0] hold_q;
    logic ld_tgl_q;
    always_ff @(negedge serial_clk or posedge serial_rst) begin
        if (serial_rst) begin
            hold_q <= 256'h0;
            ld_tgl_q <= 1'b0;
        end else if (load_valid && load_target_id == serial_device_identifier) begin // see R12 see R13
            hold_q <= {hold_q[247:0], load_byte}; // see R2 see R3 see R14
            ld_tgl_q <= ~ld_tgl_q;
        end
    end

    // word order mapping: load word L -> core word
    function automatic logic [3:0] core_of_load(input logic [3:0] l);
        logic [3:0] r;
        r = 4'h0;
        case (l)
            4'h0: r = 4'hf;
            4'h1: r = 4'h7;
            4'h2: r = 4'hb;
            4'h3: r = 4'h3;
            4'h4: r = 4'hd;
            4'h5: r = 4'h5;
            4'h6: r = 4'h9;
            4'h7: r = 4'h1;
            4'h8: r = 4'h0;
            4'h9: r = 4'h8;
            4'ha: r = 4'h4;
            4'hb: r = 4'hc;
            4'hc: r = 4'h2;
            4'hd: r = 4'ha;
            4'he: r = 4'h6;
            default: r = 4'he;
        endcase
        return r;
    endfunction : core_of_load

    // byte pair back to core word bits
    function automatic spl_word_t unpack_word(input logic [7:0] b0, input logic [7:0] b1);
        spl_word_t w;
        // first byte holds the upper two bits of each nibble, second the lower two
        w[15] = b0[7]; // see R10
        w[14] = b0[3];
        w[13] = b1[7];
        w[12] = b1[3];
        w[11] = b0[6];
        w[10] = b0[2];
        w[9] = b1[6];
        w[8] = b1[2];
        w[7] = b0[5];
        w[6] = b0[1];
        w[5] = b1[5];
        w[4] = b1[1];
        w[3] = b0[4];
        w[2] = b0[0];
        w[1] = b1[4];
        w[0] = b1[0];
        return w;
    endfunction : unpack_word

    // column view; first byte sent sits deepest (load word 0 at top)
    logic [255:0] col_view;
    always_comb begin
        col_view = 256'h0;
        for (int l = 0; l < 16; l++) begin
            col_view[core_of_load(4'(l))*16 +: 16] =
                unpack_word(hold_q[255-16*l -: 8], hold_q[247-16*l -: 8]); // see R7 see R4
        end
    end

    // width decode
    spl_width_t wsel;
    always_comb begin
        case (width_cfg) // see R11
            `SPL_WIDTH_X4: wsel = SPL_W_X4;
            `SPL_WIDTH_X8: wsel = SPL_W_X8;
            `SPL_WIDTH_X16: wsel = SPL_W_X16;
            default: wsel = SPL_W_BAD;
        endcase
    end

    // sub-column write enables
    spl_wen_t wen;
    always_comb begin
        case (wsel) // see R5 see R8
            SPL_W_X16: wen = 16'hffff;
            SPL_W_X8: wen = subcolumn_select[3] ? 16'hff00 : 16'h00ff;
            SPL_W_X4: wen = 16'h000f << {subcolumn_select[3:2], 2'b00};
            default: wen = 16'h0000;
        endcase
    end

    // crossing: load toggle into system clock for link activity visibility
    // the holding register itself is read across domains without a handshake;
    // this is safe only while the link stays quiet around a column write,
    // so the synchronised toggle lets the link_quiet_a assertion below catch a busy link.
    // tg1_q is the metastable stage, only tg2_q reads it
    logic tg1_q;
    logic tg2_q;
    logic tg3_q;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tg1_q <= 1'b0;
            tg2_q <= 1'b0;
            tg3_q <= 1'b0;
        end else begin
            tg1_q <= ld_tgl_q;
            tg2_q <= tg1_q;
            tg3_q <= tg2_q;
        end
    end

    // column write: capture data and enables; host keeps column stable (see R6 see R1)
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            core_write_q <= 1'b0;
            core_wen_q <= 16'h0;
            core_data_q <= 256'h0;
        end else begin
            core_write_q <= col_write && wsel != SPL_W_BAD;
            core_wen_q <= col_write ? wen : 16'h0;
            if (col_write) core_data_q <= col_view;
        end
    end

    // status and pin mapping: bit n mask of pin reuse per width
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            width_bad_q <= 1'b0;
            dq_pin_map_q <= 16'h0;
        end else begin
            width_bad_q <= wsel == SPL_W_BAD;
            case (wsel) // see R9
                SPL_W_X4: dq_pin_map_q <= 16'h000f;
                SPL_W_X8: dq_pin_map_q <= 16'h00ff;
                SPL_W_X16: dq_pin_map_q <= 16'hffff;
                default: dq_pin_map_q <= 16'h0;
            endcase
        end
    end

    // write enable width checks
    x4_quarter_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R8
        col_write && wsel == SPL_W_X4 |=> $countones(core_wen_q) == 4)
        else $error("x4 enable not a quarter");

    // half of the column at x8
    x8_half_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R8
        col_write && wsel == SPL_W_X8 |=> $countones(core_wen_q) == 8)
        else $error("x8 enable not a half");

    // whole column at x16
    x16_all_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R5
        col_write && wsel == SPL_W_X16 |=> core_wen_q == 16'hffff)
        else $error("x16 enable not full");

    // unsupported width never writes
    bad_width_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R11
        wsel == SPL_W_BAD |=> !core_write_q)
        else $error("write with unsupported width");

    // enables only with a write
    idle_wen_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R6
        !col_write |=> core_wen_q == 16'h0)
        else $error("enable without write");

    // x8 lower half
    x8_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R8
        col_write && wsel == SPL_W_X8 && !subcolumn_select[3] |=> core_wen_q == 16'h00ff)
        else $error("x8 lower half enable wrong");

    // x8 upper half
    x8_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R8
        col_write && wsel == SPL_W_X8 && subcolumn_select[3] |=> core_wen_q == 16'hff00)
        else $error("x8 upper half enable wrong");

    // x4 first quarter
    x4_first_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R8
        col_write && wsel == SPL_W_X4 && subcolumn_select[3:2] == 2'h0 |=> core_wen_q == 16'h000f)
        else $error("x4 quarter zero enable wrong");

    // x4 second quarter
    x4_second_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R8
        col_write && wsel == SPL_W_X4 && subcolumn_select[3:2] == 2'h1 |=> core_wen_q == 16'h00f0)
        else $error("x4 quarter one enable wrong");

    // x4 third quarter
    x4_third_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R8
        col_write && wsel == SPL_W_X4 && subcolumn_select[3:2] == 2'h2 |=> core_wen_q == 16'h0f00)
        else $error("x4 quarter two enable wrong");

    // x4 fourth quarter
    x4_fourth_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R8
        col_write && wsel == SPL_W_X4 && subcolumn_select[3:2] == 2'h3 |=> core_wen_q == 16'hf000)
        else $error("x4 quarter three enable wrong");

    // write pulse only after a command
    wr_follow_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R6
        core_write_q |-> $past(col_write))
        else $error("write pulse without command");

    // supported width always writes
    wr_taken_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R6
        col_write && wsel != SPL_W_BAD |=> core_write_q)
        else $error("command at valid width lost");

    // column captured on the command
    data_take_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R7
        col_write |=> core_data_q == $past(col_view))
        else $error("column not captured");

    // column held between commands
    data_keep_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R14
        !col_write |=> $stable(core_data_q))
        else $error("column changed without command");

    // status flag set on bad width
    flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R11
        wsel == SPL_W_BAD |=> width_bad_q)
        else $error("bad width not flagged");

    // status flag clear on good width
    flag_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R11
        wsel != SPL_W_BAD |=> !width_bad_q)
        else $error("good width flagged");

    // pins in use at x4
    map_x4_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R9
        wsel == SPL_W_X4 |=> dq_pin_map_q == 16'h000f)
        else $error("x4 pin map wrong");

    // pins in use at x8
    map_x8_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R9
        wsel == SPL_W_X8 |=> dq_pin_map_q == 16'h00ff)
        else $error("x8 pin map wrong");

    // pins in use at x16
    map_x16_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R9
        wsel == SPL_W_X16 |=> dq_pin_map_q == 16'hffff)
        else $error("x16 pin map wrong");

    // link quiet while a column is copied
    link_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // see R6
        col_write |-> tg2_q == tg3_q)
        else $error("load arrived around a column write");

    // new byte enters at the bottom
    shift_in_a: assert property (@(negedge serial_clk) disable iff (serial_rst) // see R3
        load_valid && load_target_id == serial_device_identifier
        |=> hold_q[7:0] == $past(load_byte) && hold_q[15:8] == $past(hold_q[7:0]))
        else $error("byte not shifted by eight");

    // older bytes move deeper
    shift_deep_a: assert property (@(negedge serial_clk) disable iff (serial_rst) // see R3
        load_valid && load_target_id == serial_device_identifier
        |=> hold_q[255:8] == $past(hold_q[247:0]))
        else $error("older bytes not advanced");

    // one toggle per byte
    one_byte_a: assert property (@(negedge serial_clk) disable iff (serial_rst) // see R2
        load_valid && load_target_id == serial_device_identifier
        |=> ld_tgl_q != $past(ld_tgl_q))
        else $error("packet not counted once");

    // no toggle without a packet
    tgl_keep_a: assert property (@(negedge serial_clk) disable iff (serial_rst) // see R2
        !load_valid |=> $stable(ld_tgl_q))
        else $error("toggle without packet");

    // holding register kept without a load
    hold_keep_a: assert property (@(negedge serial_clk) disable iff (serial_rst) // see R14
        !load_valid |=> $stable(hold_q))
        else $error("holding register changed without load");

    // loads for other devices ignored
    other_id_a: assert property (@(negedge serial_clk) disable iff (serial_rst) // see R13
        load_target_id != serial_device_identifier |=> $stable(hold_q))
        else $error("load taken for another device");

    // main scenarios
    cv_x4_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        col_write && wsel == SPL_W_X4);
    cv_x8_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        col_write && wsel == SPL_W_X8);
    cv_x16_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        col_write && wsel == SPL_W_X16);
    cv_bad_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        col_write && wsel == SPL_W_BAD);
    cv_load_c: cover property (@(negedge serial_clk) disable iff (serial_rst) load_valid);
endmodule : spl_load

// ==== spl_ctrl_model.sv ====
`timescale 1ns/1ps
module spl_ctrl_model (
    output logic serial_clk,
    output logic serial_rst,
    output logic load_valid,
    output logic [7:0] load_byte,
    output logic [5:0] load_target_id
);
    int core_of_load [16] = '{15, 7, 11, 3, 13, 5, 9, 1, 0, 8, 4, 12, 2, 10, 6, 14};
    // link idles low, reset asserted at power up
    initial begin
        serial_clk = 1'b0;
        serial_rst = 1'b1;
        load_valid = 1'b0;
        load_byte = 8'h00;
        load_target_id = 6'h00;
    end
    // one clock per byte, data changes just after the rise
    task automatic edge_out(input logic v, input logic [7:0] b, input logic [5:0] id);
        serial_clk = 1'b1;
        #1;
        load_valid = v;
        load_byte = b;
        load_target_id = id;
        #6.5 serial_clk = 1'b0;
        #7.5;
    endtask : edge_out
    task automatic reset_link();
        repeat (3) edge_out(1'b0, ~load_byte, ~load_target_id);
        serial_rst = 1'b0;
    endtask : reset_link
    // full column as 32 bytes, idle lines then inverted
    task automatic load_column(input logic [255:0] col, input logic [5:0] id);
        logic [15:0] w;
        #3.3;
        for (int l = 0; l < 16; l++) begin
            w = col[16*core_of_load[l] +: 16];
            edge_out(1'b1, {w[15], w[11], w[7], w[3], w[14], w[10], w[6], w[2]}, id);
            edge_out(1'b1, {w[13], w[9], w[5], w[1], w[12], w[8], w[4], w[0]}, id);
        end
        edge_out(1'b0, ~load_byte, ~id);
    endtask : load_column
endmodule : spl_ctrl_model

// ==== test_serial_pattern_load_holding_register.sv ====
`timescale 1ns/1ps
module test_serial_pattern_load_holding_register;
    logic clk_sys, sys_rst, serial_clk, serial_rst, load_valid, col_write, core_write_q, width_bad_q;
    logic [7:0] load_byte;
    logic [5:0] load_target_id, own_id;
    logic [2:0] width_cfg;
    logic [3:0] subcolumn_select;
    logic [15:0] core_wen_q, dq_pin_map_q;
    logic [255:0] core_data_q, col_a;
    int fails = 0;
    int compares = 0;
    spl_load spl_load_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .serial_clk(serial_clk),
        .serial_rst(serial_rst), .load_valid(load_valid), .load_byte(load_byte),
        .load_target_id(load_target_id), .serial_device_identifier(own_id),
        .width_cfg(width_cfg), .col_write(col_write), .subcolumn_select(subcolumn_select),
        .core_write_q(core_write_q), .core_wen_q(core_wen_q), .core_data_q(core_data_q),
        .width_bad_q(width_bad_q), .dq_pin_map_q(dq_pin_map_q));
    spl_ctrl_model spl_ctrl_model_i (.serial_clk(serial_clk), .serial_rst(serial_rst),
        .load_valid(load_valid), .load_byte(load_byte), .load_target_id(load_target_id));
    // system clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    // load over the link, then stay quiet before any write
    task automatic load(input logic [255:0] col, input logic [5:0] id);
        spl_ctrl_model_i.load_column(col, id);
        repeat (4) @(negedge clk_sys);
    endtask : load
    // back-to-back column writes, one per sub-column
    task automatic wr_seq(input int n, input int step, input logic [15:0] base, input int sh,
        input logic [255:0] dat);
        for (int k = 0; k <= n; k++) begin
            @(negedge clk_sys);
            if (k > 0) begin
                chk(core_write_q, base != 16'h0000);
                chk(core_wen_q, base << (sh * (k - 1)));
                chk(width_bad_q, base == 16'h0000);
                if (base != 16'h0000) begin
                    chk(core_data_q, dat);
                    chk(dq_pin_map_q, base);
                end
            end
            col_write = (k < n);
            subcolumn_select = 4'(k * step);
        end
        @(negedge clk_sys);
        chk(core_write_q, 1'b0);
        chk(core_wen_q, 16'h0000);
    endtask : wr_seq
    task automatic t_widths();
        width_cfg = 3'h4;
        load(col_a, own_id);
        wr_seq(1, 0, 16'hffff, 0, col_a);
        width_cfg = 3'h3;
        load(~col_a, own_id);
        wr_seq(2, 8, 16'h00ff, 8, ~col_a);
        width_cfg = 3'h2;
        load(col_a, own_id ^ 6'h01);
        wr_seq(4, 4, 16'h000f, 4, ~col_a);
    endtask : t_widths
    task automatic t_bad();
        for (int c = 0; c < 8; c++) begin
            if (c < 2 || c > 4) begin
                width_cfg = 3'(c);
                repeat (2) @(negedge clk_sys);
                wr_seq(1, 0, 16'h0000, 0, col_a);
            end
        end
    endtask : t_bad
    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    // main sequence
    initial begin
        sys_rst = 1'b1;
        col_write = 1'b0;
        subcolumn_select = 4'h0;
        width_cfg = 3'h4;
        own_id = 6'h2a;
        for (int i = 0; i < 16; i++) col_a[16*i +: 16] = 16'ha5c3 ^ 16'(i * 16'h1357);
        spl_ctrl_model_i.reset_link();
        repeat (10) @(negedge clk_sys);
        sys_rst = 1'b0;
        @(negedge clk_sys);
        t_widths();
        t_bad();
        final_report();
    end
    // hang guard
    initial begin
        #200000;
        fails++;
        final_report();
    end
endmodule : test_serial_pattern_load_holding_register
